//--- pcps_bank.sv
/*
 * pcps_bank: parameter and status bank of a load power controller, reached by the
 * remote host through the secondary port command interface.
 * Assumes: port front end delivers decoded one-cycle write/read strobes on clk_i;
 * alarm and digital input levels arrive asynchronously and are synchronised here.
 */
// Functional notes
// - secondary port type: disabled, Ethernet, RS-485
// - read only refuses writes, stops watchdog
// - outside Modbus RTU, host writes each interval or output disables
// - eight bit port address, default zero
// - baud 9600/19200/38400/115200, default 9600
// - current band 0-255 percent, default 15
// - power band 0-255 percent, default 5
// - remote source input 1/2, digital input overrides
// - retransmit selector, default power
// - retransmit scale 0-9999, zero at bottom
// - signal type, default 4-20mA, offset on for 4-20mA
// - safety ramp nonzero duration enables, 50 ms
// - safety ramp only after off time
// - temperature state disabled or over temp
// - target level source remote or local
// - soft start ramps target level changes
// - start ramp half cycles on turn-on
// - status alarm bits set when active
// - status output, inputs, bakeout bits
// - bit 15 latches thermal until power cycle
`timescale 1ns/1ps
module pcps_bank #(
    parameter int WDOG_TICKS = 100,   // watchdog interval in 50 ms ticks
    parameter int TICK_CYCLES = pcps_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // command port from the secondary port front end
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [4:0] idx_i,
    input wire logic [15:0] wdata_i,
    input wire logic modbus_rtu_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic wr_refused_o,
    // asynchronous plant levels
    input wire logic [15:0] alarm_i,
    input wire logic din_sel_en_i,
    input wire logic local_target_i,
    input wire logic load_on_i,
    input wire logic run_en_i,
    // configuration towards the control logic
    output logic [1:0] port_type_o,
    output logic [7:0] port_addr_o,
    output logic [1:0] port_baud_o,
    output logic [7:0] pb_current_o,
    output logic [7:0] pb_power_o,
    output logic remote_src_o,
    output logic [2:0] retx_sel_o,
    output logic [13:0] retx_scale_o,
    output logic [1:0] retx_type_o,
    output logic retx_offset_o,
    output logic [7:0] soft_start_o,
    output logic [9:0] start_ramp_o,
    output logic [15:0] safe_dur_o,
    output logic safe_ramp_en_o,
    output logic safe_ramp_arm_o,
    output logic output_en_o,
    output logic comm_timeout_alarm_o
);
    initial
    begin
        if (WDOG_TICKS < 1 || WDOG_TICKS > 65535)
            $error("watchdog interval out of range");
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [15:0] alarm_m;
        logic [15:0] alarm_s;
        logic [3:0] lvl_m;
        logic [3:0] lvl_s;
        logic [1:0] port_type;
        logic read_only;
        logic [7:0] port_addr;
        logic [1:0] port_baud;
        logic [7:0] pb_current;
        logic [7:0] pb_power;
        logic remote_src;
        logic [2:0] retx_sel;
        logic [13:0] retx_scale;
        logic [1:0] retx_type;
        logic [15:0] safe_dur;
        logic [15:0] safe_off;
        logic [7:0] soft_start;
        logic [9:0] start_ramp;
        logic [15:0] wdog_cnt;
        logic comm_timeout;
        logic [15:0] off_cnt;
        logic therm_latch;
        logic [15:0] rdata;
        logic rvalid;
        logic refused;
    } pcps_bank_st_t;

    pcps_bank_st_t st_r;
    pcps_bank_st_t st_nxt;
    pcps_tick_if tk ();
    logic [15:0] status_w;
    logic din_sel;
    logic eff_src;
    logic wr_ok;

    pcps_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tk(tk)
    );

    // ************************************************************
    // status word assembly
    // ************************************************************
    // lvl_s: din1, din2, select enable, local
    always_comb
    begin
        status_w = 16'h0000;
        status_w[pcps_pkg::ST_SHORT] = st_r.alarm_s[pcps_pkg::ST_SHORT];
        status_w[pcps_pkg::ST_HTR_BREAK] = st_r.alarm_s[pcps_pkg::ST_HTR_BREAK];
        status_w[pcps_pkg::ST_CUR_LIMIT] = st_r.alarm_s[pcps_pkg::ST_CUR_LIMIT];
        status_w[pcps_pkg::ST_THERMAL] = st_r.alarm_s[pcps_pkg::ST_THERMAL];
        status_w[pcps_pkg::ST_COMM_TIMEOUT] = st_r.comm_timeout;
        status_w[pcps_pkg::ST_UNBALANCE] = st_r.alarm_s[pcps_pkg::ST_UNBALANCE];
        status_w[pcps_pkg::ST_PHASE_LOSS] = st_r.alarm_s[pcps_pkg::ST_PHASE_LOSS];
        status_w[pcps_pkg::ST_OUT_EN] = output_en_o;
        status_w[pcps_pkg::ST_DIN1] = st_r.lvl_s[0];
        status_w[pcps_pkg::ST_DIN2] = st_r.lvl_s[1];
        status_w[pcps_pkg::ST_BAKEOUT] = st_r.alarm_s[pcps_pkg::ST_BAKEOUT];
        status_w[pcps_pkg::ST_THERM_LATCH] = st_r.therm_latch;
    end

    // input 1 on picks input 2
    assign din_sel = st_r.lvl_s[0];
    assign eff_src = st_r.lvl_s[2] ? din_sel : st_r.remote_src;
    // writes allowed only in read-write mode
    assign wr_ok = wr_i && !st_r.read_only;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.alarm_m = alarm_i;
        st_nxt.alarm_s = st_r.alarm_m;
        st_nxt.lvl_m = {local_target_i, din_sel_en_i, alarm_i[pcps_pkg::ST_DIN2],
            alarm_i[pcps_pkg::ST_DIN1]};
        st_nxt.lvl_s = st_r.lvl_m;
        st_nxt.rvalid = rd_i;
        st_nxt.refused = wr_i && st_r.read_only;
        if (st_r.alarm_s[pcps_pkg::ST_THERMAL])
            st_nxt.therm_latch = 1'b1;
        if (load_on_i)
            st_nxt.off_cnt = 16'h0000;
        else if (tk.tick && st_r.off_cnt != 16'hFFFF)
            st_nxt.off_cnt = st_r.off_cnt + 16'h0001;
        if (st_r.read_only || modbus_rtu_i || wr_ok)
        begin
            st_nxt.wdog_cnt = 16'h0000;
            st_nxt.comm_timeout = 1'b0;
        end
        else if (tk.tick)
        begin
            if (st_r.wdog_cnt >= 16'(WDOG_TICKS - 1))
                st_nxt.comm_timeout = 1'b1;
            else
                st_nxt.wdog_cnt = st_r.wdog_cnt + 16'h0001;
        end
        if (wr_ok)
        begin
            case (idx_i)
                pcps_pkg::IDX_PORT_TYPE:
                    if (wdata_i[1:0] != 2'h3)
                        st_nxt.port_type = wdata_i[1:0];
                pcps_pkg::IDX_PORT_ACCESS:
                    st_nxt.read_only = wdata_i[0];
                pcps_pkg::IDX_PORT_ADDR:
                    st_nxt.port_addr = wdata_i[7:0];
                pcps_pkg::IDX_PORT_BAUD:
                    st_nxt.port_baud = wdata_i[1:0];
                pcps_pkg::IDX_PB_CURRENT:
                    st_nxt.pb_current = wdata_i[7:0];
                pcps_pkg::IDX_PB_POWER:
                    st_nxt.pb_power = wdata_i[7:0];
                pcps_pkg::IDX_REMOTE_SRC:
                    st_nxt.remote_src = wdata_i[0];
                pcps_pkg::IDX_RETX_SEL:
                    if (wdata_i <= 16'(pcps_pkg::PCPS_RETX_POWER))
                        st_nxt.retx_sel = wdata_i[2:0];
                pcps_pkg::IDX_RETX_SCALE:
                    if (wdata_i <= 16'(pcps_pkg::MAX_RETX_SCALE))
                        st_nxt.retx_scale = wdata_i[13:0];
                pcps_pkg::IDX_RETX_TYPE:
                    if (wdata_i[1:0] != 2'h3)
                        st_nxt.retx_type = wdata_i[1:0];
                pcps_pkg::IDX_SAFE_DUR:
                    st_nxt.safe_dur = wdata_i;
                pcps_pkg::IDX_SAFE_OFF:
                    st_nxt.safe_off = wdata_i;
                pcps_pkg::IDX_SOFT_START:
                    st_nxt.soft_start = wdata_i[7:0];
                pcps_pkg::IDX_START_RAMP:
                    st_nxt.start_ramp = wdata_i[9:0];
                default:
                    ;
            endcase
        end
        // read mux
        case (idx_i)
            pcps_pkg::IDX_PORT_TYPE: st_nxt.rdata = {14'h0000, st_r.port_type};
            pcps_pkg::IDX_PORT_ACCESS: st_nxt.rdata = {15'h0000, st_r.read_only};
            pcps_pkg::IDX_PORT_ADDR: st_nxt.rdata = {8'h00, st_r.port_addr};
            pcps_pkg::IDX_PORT_BAUD: st_nxt.rdata = {14'h0000, st_r.port_baud};
            pcps_pkg::IDX_PB_CURRENT: st_nxt.rdata = {8'h00, st_r.pb_current};
            pcps_pkg::IDX_PB_POWER: st_nxt.rdata = {8'h00, st_r.pb_power};
            pcps_pkg::IDX_REMOTE_SRC: st_nxt.rdata = {15'h0000, eff_src};
            pcps_pkg::IDX_RETX_SEL: st_nxt.rdata = {13'h0000, st_r.retx_sel};
            pcps_pkg::IDX_RETX_SCALE: st_nxt.rdata = {2'h0, st_r.retx_scale};
            pcps_pkg::IDX_RETX_TYPE: st_nxt.rdata = {14'h0000, st_r.retx_type};
            pcps_pkg::IDX_SAFE_DUR: st_nxt.rdata = st_r.safe_dur;
            pcps_pkg::IDX_SAFE_OFF: st_nxt.rdata = st_r.safe_off;
            pcps_pkg::IDX_SOFT_START: st_nxt.rdata = {8'h00, st_r.soft_start};
            pcps_pkg::IDX_START_RAMP: st_nxt.rdata = {6'h00, st_r.start_ramp};
            // unused bits are zero in status_w
            pcps_pkg::IDX_STATUS: st_nxt.rdata = status_w;
            pcps_pkg::IDX_TEMP_STATE:
                st_nxt.rdata = {15'h0000, st_r.alarm_s[pcps_pkg::ST_THERMAL]};
            pcps_pkg::IDX_SP_SOURCE: st_nxt.rdata = {15'h0000, st_r.lvl_s[3]};
            default: st_nxt.rdata = 16'h0000;
        endcase
        if (!rd_i)
            st_nxt.rdata = st_r.rdata;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
            st_r.port_type <= pcps_pkg::PCPS_PORT_DISABLED;
            st_r.port_addr <= pcps_pkg::RST_PORT_ADDR;
            st_r.port_baud <= pcps_pkg::PCPS_BAUD_9600;
            st_r.pb_current <= pcps_pkg::RST_PB_CURRENT;
            st_r.pb_power <= pcps_pkg::RST_PB_POWER;
            st_r.retx_sel <= pcps_pkg::PCPS_RETX_POWER;
            st_r.retx_scale <= pcps_pkg::RST_RETX_SCALE;
            st_r.retx_type <= pcps_pkg::PCPS_SIG_4_20MA;
            st_r.safe_dur <= pcps_pkg::RST_SAFE_DUR;
            st_r.safe_off <= pcps_pkg::RST_SAFE_OFF;
            st_r.soft_start <= pcps_pkg::RST_SOFT_START;
            st_r.start_ramp <= pcps_pkg::RST_START_RAMP;
        end
        else
            st_r <= st_nxt;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign port_type_o = st_r.port_type;
    assign port_addr_o = st_r.port_addr;
    assign port_baud_o = st_r.port_baud;
    assign pb_current_o = st_r.pb_current;
    assign pb_power_o = st_r.pb_power;
    assign remote_src_o = eff_src;
    assign retx_sel_o = st_r.retx_sel;
    assign retx_scale_o = st_r.retx_scale;
    assign retx_type_o = st_r.retx_type;
    assign retx_offset_o = (st_r.retx_type == pcps_pkg::PCPS_SIG_4_20MA);
    assign soft_start_o = st_r.soft_start;
    assign start_ramp_o = st_r.start_ramp;
    assign safe_dur_o = st_r.safe_dur;
    assign safe_ramp_en_o = (st_r.safe_dur != 16'h0000);
    assign safe_ramp_arm_o = safe_ramp_en_o && (st_r.off_cnt >= st_r.safe_off);
    assign output_en_o = run_en_i & !st_r.comm_timeout;
    assign comm_timeout_alarm_o = st_r.comm_timeout;
    assign rdata_o = st_r.rdata;
    assign rvalid_o = st_r.rvalid;
    assign wr_refused_o = st_r.refused;
endmodule

//--- pcps_pkg.sv
/*
 * pcps_pkg: shared constants for the power controller parameter and status bank.
 * Assumes: compiled first.
 */
package pcps_pkg;

    // ************************************************************
    // parameter indices on the secondary command port
    // ************************************************************
    localparam logic [4:0] IDX_PORT_TYPE = 5'h00;
    localparam logic [4:0] IDX_PORT_ACCESS = 5'h01;
    localparam logic [4:0] IDX_PORT_ADDR = 5'h02;
    localparam logic [4:0] IDX_PORT_BAUD = 5'h03;
    localparam logic [4:0] IDX_PB_CURRENT = 5'h04;
    localparam logic [4:0] IDX_PB_POWER = 5'h05;
    localparam logic [4:0] IDX_REMOTE_SRC = 5'h06;
    localparam logic [4:0] IDX_RETX_SEL = 5'h07;
    localparam logic [4:0] IDX_RETX_SCALE = 5'h08;
    localparam logic [4:0] IDX_RETX_TYPE = 5'h09;
    localparam logic [4:0] IDX_SAFE_DUR = 5'h0A;
    localparam logic [4:0] IDX_SAFE_OFF = 5'h0B;
    localparam logic [4:0] IDX_SOFT_START = 5'h0C;
    localparam logic [4:0] IDX_START_RAMP = 5'h0D;
    localparam logic [4:0] IDX_STATUS = 5'h0E;
    localparam logic [4:0] IDX_TEMP_STATE = 5'h0F;
    localparam logic [4:0] IDX_SP_SOURCE = 5'h10;

    // ************************************************************
    // encodings
    // ************************************************************
    typedef enum logic [1:0] {
        PCPS_PORT_DISABLED = 2'h0,
        PCPS_PORT_ETHERNET = 2'h1,
        PCPS_PORT_RS485 = 2'h2
    } pcps_port_t;

    typedef enum logic [1:0] {
        PCPS_BAUD_9600 = 2'h0,
        PCPS_BAUD_19200 = 2'h1,
        PCPS_BAUD_38400 = 2'h2,
        PCPS_BAUD_115200 = 2'h3
    } pcps_baud_t;

    typedef enum logic [2:0] {
        PCPS_RETX_NONE = 3'h0,
        PCPS_RETX_TARGET = 3'h1,
        PCPS_RETX_VOLT = 3'h2,
        PCPS_RETX_CURR = 3'h3,
        PCPS_RETX_POWER = 3'h4
    } pcps_retx_t;

    typedef enum logic [1:0] {
        PCPS_SIG_0_10V = 2'h0,
        PCPS_SIG_4_20MA = 2'h1,
        PCPS_SIG_0_20MA = 2'h2
    } pcps_sig_t;

    // ************************************************************
    // reset values and limits
    // ************************************************************
    localparam logic [7:0] RST_PORT_ADDR = 8'h00;
    localparam logic [7:0] RST_PB_CURRENT = 8'h0F;    // 15 percent
    localparam logic [7:0] RST_PB_POWER = 8'h05;      // 5 percent
    localparam logic [13:0] RST_RETX_SCALE = 14'h0000;
    localparam logic [13:0] MAX_RETX_SCALE = 14'h270F; // 9999
    localparam logic [15:0] RST_SAFE_DUR = 16'h000A;   // 10 x 50 ms
    localparam logic [15:0] RST_SAFE_OFF = 16'h00C8;   // 200 x 50 ms
    localparam logic [7:0] RST_SOFT_START = 8'h08;    // 8 x 50 ms
    localparam logic [9:0] RST_START_RAMP = 10'h000;

    // ************************************************************
    // status word bit positions
    // ************************************************************
    localparam int ST_SHORT = 0;
    localparam int ST_HTR_BREAK = 1;
    localparam int ST_OUT_EN = 2;
    localparam int ST_CUR_LIMIT = 4;
    localparam int ST_THERMAL = 5;
    localparam int ST_COMM_TIMEOUT = 6;
    localparam int ST_DIN1 = 8;
    localparam int ST_DIN2 = 9;
    localparam int ST_UNBALANCE = 10;
    localparam int ST_PHASE_LOSS = 13;
    localparam int ST_BAKEOUT = 14;
    localparam int ST_THERM_LATCH = 15;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 50;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

endpackage

//--- pcps_tick_if.sv
/*
 * pcps_tick_if: carries the 50 ms time base from the tick divider to the bank.
 * Assumes: both ends on clk_i.
 */
`timescale 1ns/1ps
interface pcps_tick_if;
    logic tick;
    modport source (output tick);
    modport sink (input tick);
endinterface

//--- pcps_tick_gen.sv
/*
 * pcps_tick_gen: divides clk_i down to a one-cycle pulse every 50 ms.
 * Assumes: clk_i at the rate named in pcps_pkg.
 */
`timescale 1ns/1ps
module pcps_tick_gen #(
    parameter int TICK_CYCLES = pcps_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    pcps_tick_if.source tk
);
    initial
    begin
        if (TICK_CYCLES < 1 || TICK_CYCLES > 32'h7FFF_FFFF)
            $error("tick count out of range");
    end

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } pcps_tick_st_t;

    pcps_tick_st_t st_r;
    pcps_tick_st_t st_nxt;

    // free-running divider; one pulse per wrap
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt == 32'(TICK_CYCLES - 1))
        begin
            st_nxt.cnt = 32'h0000_0000;
            st_nxt.tick = 1'b1;
        end
        else
            st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tk.tick = st_r.tick;
endmodule

//--- pcps_bank_properties.sv
/* pcps_bank_properties: port-level assertions for pcps_bank, bound at the foot.
   Assumes: clk_i, rst_n_i async active low. */
`timescale 1ns/1ps
module pcps_bank_properties (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [4:0] idx_i,
    input wire logic [15:0] wdata_i,
    input wire logic modbus_rtu_i,
    input wire logic run_en_i,
    input wire logic [15:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic wr_refused_o,
    input wire logic [7:0] port_addr_o,
    input wire logic [1:0] port_baud_o,
    input wire logic [2:0] retx_sel_o,
    input wire logic [1:0] retx_type_o,
    input wire logic retx_offset_o,
    input wire logic [15:0] safe_dur_o,
    input wire logic safe_ramp_en_o,
    input wire logic output_en_o,
    input wire logic comm_timeout_alarm_o
);
    // one domain for all properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ************************************************************
    // configuration writes and derived flags
    // ************************************************************
    addr_write_a: assert property (wr_i && idx_i == pcps_pkg::IDX_PORT_ADDR |=>
        port_addr_o == $past(wdata_i[7:0]) || wr_refused_o) else $error("address not taken");
    baud_write_a: assert property (wr_i && idx_i == pcps_pkg::IDX_PORT_BAUD |=>
        port_baud_o == $past(wdata_i[1:0]) || wr_refused_o) else $error("baud not taken");
    bad_selector_a: assert property (wr_i && idx_i == pcps_pkg::IDX_RETX_SEL
        && wdata_i > 16'h0004 |=> $stable(retx_sel_o)) else $error("selector took bad code");
    offset_follows_type_a: assert property (retx_offset_o == (retx_type_o == 2'h1))
        else $error("offset does not follow type");
    ramp_enable_a: assert property (safe_ramp_en_o == (safe_dur_o != 16'h0000))
        else $error("ramp enable wrong");

    // ************************************************************
    // watchdog and status word
    // ************************************************************
    output_gate_a: assert property (output_en_o == (run_en_i && !comm_timeout_alarm_o))
        else $error("output enable wrong");
    modbus_clears_a: assert property (modbus_rtu_i |=> !comm_timeout_alarm_o)
        else $error("timeout under modbus");
    status_comm_bit_a: assert property (rvalid_o && $past(idx_i) == pcps_pkg::IDX_STATUS
        |-> rdata_o[6] == $past(comm_timeout_alarm_o)) else $error("status bit 6 wrong");
    status_out_bit_a: assert property (rvalid_o && $past(idx_i) == pcps_pkg::IDX_STATUS
        |-> rdata_o[2] == $past(output_en_o)) else $error("status bit 2 wrong");
    unused_zero_a: assert property (rvalid_o && $past(idx_i) == pcps_pkg::IDX_STATUS
        |-> rdata_o[12:11] == 2'h0 && !rdata_o[7] && !rdata_o[3]) else $error("unused bit set");
endmodule

bind pcps_bank pcps_bank_properties pcps_bank_properties_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .idx_i(idx_i), .wdata_i(wdata_i),
    .modbus_rtu_i(modbus_rtu_i), .run_en_i(run_en_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .wr_refused_o(wr_refused_o), .port_addr_o(port_addr_o), .port_baud_o(port_baud_o),
    .retx_sel_o(retx_sel_o), .retx_type_o(retx_type_o), .retx_offset_o(retx_offset_o),
    .safe_dur_o(safe_dur_o), .safe_ramp_en_o(safe_ramp_en_o), .output_en_o(output_en_o),
    .comm_timeout_alarm_o(comm_timeout_alarm_o));

//--- pcps_host.sv
/* pcps_host: remote host model on the secondary port.
   Assumes: the bank answers on clk_i one cycle after it takes a request. */
`timescale 1ns/1ps
module pcps_host (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    input wire logic wr_refused_i,
    output logic wr_o,
    output logic rd_o,
    output logic [4:0] idx_o,
    output logic [15:0] wdata_o
);
    // strobes idle low from time zero
    initial
    begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        idx_o = 5'h00;
        wdata_o = 16'h0000;
    end

    // host keepalive write
    // released lines show the inverse
    task automatic wr(input logic [4:0] idx, input logic [15:0] data, output logic refused);
        @(posedge clk_i);
        wr_o <= 1'b1;
        idx_o <= idx;
        wdata_o <= data;
        @(posedge clk_i);
        wr_o <= 1'b0;
        idx_o <= ~idx;
        wdata_o <= ~data;
        @(posedge clk_i);
        refused = wr_refused_i;
    endtask

    // answer taken where rvalid is sampled
    task automatic rd(input logic [4:0] idx, output logic [16:0] ans);
        @(posedge clk_i);
        rd_o <= 1'b1;
        idx_o <= idx;
        @(posedge clk_i);
        rd_o <= 1'b0;
        idx_o <= ~idx;
        @(posedge clk_i);
        ans = {rvalid_i, rdata_i};
    endtask
endmodule

//--- test_power_ctrl_param_status.sv
/* test_power_ctrl_param_status: self-checking bench for pcps_bank with a host model.
   Assumes: short tick (10 clocks) and watchdog (3 ticks) parameters. */
`timescale 1ns/1ps
module test_power_ctrl_param_status;
    typedef struct packed {logic [4:0] idx; logic [15:0] wd; logic [15:0] exp;} pcps_row_t;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr_i, rd_i, rvalid_o, wr_refused_o, remote_src_o, retx_offset_o, rf;
    logic safe_ramp_en_o, safe_ramp_arm_o, output_en_o, comm_timeout_alarm_o;
    logic modbus_rtu_i = 1'b1;
    logic din_sel_en_i = 1'b0;
    logic local_target_i = 1'b0;
    logic load_on_i = 1'b0;
    logic run_en_i = 1'b1;
    logic [15:0] alarm_i = 16'h0000;
    logic [4:0] idx_i;
    logic [15:0] wdata_i, rdata_o, safe_dur_o;
    logic [16:0] ans;
    logic [1:0] port_type_o, port_baud_o, retx_type_o;
    logic [7:0] port_addr_o, pb_current_o, pb_power_o, soft_start_o;
    logic [2:0] retx_sel_o;
    logic [13:0] retx_scale_o;
    logic [9:0] start_ramp_o;
    int failures = 0;
    int num_checks = 0;
    int n;
    // write, expected readback
    pcps_row_t rows [30] = '{'{5'h00, 16'h1, 16'h1}, '{5'h00, 16'h2, 16'h2}, '{5'h00, 16'h3, 16'h2},
        '{5'h02, 16'hFF, 16'hFF}, '{5'h03, 16'h1, 16'h1}, '{5'h03, 16'h2, 16'h2},
        '{5'h03, 16'h3, 16'h3}, '{5'h03, 16'h0, 16'h0}, '{5'h04, 16'h0, 16'h0},
        '{5'h05, 16'hFF, 16'hFF}, '{5'h06, 16'h1, 16'h1}, '{5'h07, 16'h0, 16'h0},
        '{5'h07, 16'h1, 16'h1}, '{5'h07, 16'h2, 16'h2}, '{5'h07, 16'h3, 16'h3},
        '{5'h07, 16'h5, 16'h3}, '{5'h07, 16'h4, 16'h4}, '{5'h08, 16'h270F, 16'h270F},
        '{5'h08, 16'h2710, 16'h270F}, '{5'h09, 16'h0, 16'h0}, '{5'h09, 16'h2, 16'h2},
        '{5'h09, 16'h3, 16'h2}, '{5'h09, 16'h1, 16'h1}, '{5'h0A, 16'h0, 16'h0},
        '{5'h0A, 16'hFFFF, 16'hFFFF}, '{5'h0B, 16'h1, 16'h1}, '{5'h0C, 16'hFF, 16'hFF},
        '{5'h0D, 16'h3FF, 16'h3FF}, '{5'h13, 16'h1234, 16'h0}, '{5'h02, 16'h0, 16'h0}};

    pcps_bank #(.WDOG_TICKS(3), .TICK_CYCLES(10)) pcps_bank_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .wr_i(wr_i), .rd_i(rd_i), .idx_i(idx_i), .wdata_i(wdata_i), .modbus_rtu_i(modbus_rtu_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .wr_refused_o(wr_refused_o), .alarm_i(alarm_i),
        .din_sel_en_i(din_sel_en_i), .local_target_i(local_target_i), .load_on_i(load_on_i),
        .run_en_i(run_en_i), .port_type_o(port_type_o), .port_addr_o(port_addr_o),
        .port_baud_o(port_baud_o), .pb_current_o(pb_current_o), .pb_power_o(pb_power_o),
        .remote_src_o(remote_src_o), .retx_sel_o(retx_sel_o), .retx_scale_o(retx_scale_o),
        .retx_type_o(retx_type_o), .retx_offset_o(retx_offset_o), .soft_start_o(soft_start_o),
        .start_ramp_o(start_ramp_o), .safe_dur_o(safe_dur_o), .safe_ramp_en_o(safe_ramp_en_o),
        .safe_ramp_arm_o(safe_ramp_arm_o), .output_en_o(output_en_o),
        .comm_timeout_alarm_o(comm_timeout_alarm_o));
    pcps_host pcps_host_i (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
        .wr_refused_i(wr_refused_o), .wr_o(wr_i), .rd_o(rd_i), .idx_o(idx_i), .wdata_o(wdata_i));

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    // counted compare
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %0t %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // reset, then defaults
    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        check({port_type_o, port_addr_o, port_baud_o, pb_current_o, pb_power_o, retx_sel_o},
            {2'h0, 8'h00, 2'h0, 8'h0F, 8'h05, 3'h4});
        check({retx_scale_o, retx_type_o, soft_start_o, start_ramp_o, safe_dur_o, remote_src_o},
            {14'h0, 2'h1, 8'h08, 10'h0, 16'h000A, 1'b0});
        pcps_host_i.rd(5'h0B, ans);
        check(ans, {1'b1, 16'h00C8});
    endtask

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk_i);
        failures++;
        complete_run();
    end

    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            pcps_host_i.wr(rows[i].idx, rows[i].wd, rf);
            pcps_host_i.rd(rows[i].idx, ans);
            check(ans, {1'b1, rows[i].exp});
        end
        // all alarm_i bits high, then drop
        alarm_i <= 16'hFFFF;
        repeat (4) @(posedge clk_i);
        pcps_host_i.rd(5'h0F, ans);
        check(ans, {1'b1, 16'h0001});
        pcps_host_i.rd(5'h0E, ans);
        check(ans, {1'b1, 16'hE737});
        alarm_i <= 16'h0000;
        local_target_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        pcps_host_i.wr(5'h0E, 16'hFFFF, rf);
        pcps_host_i.rd(5'h0E, ans);
        check(ans, {1'b1, 16'h8004});
        pcps_host_i.rd(5'h10, ans);
        check(ans, {1'b1, 16'h0001});
        // digital input overrides stored source
        din_sel_en_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(remote_src_o, 1'b0);
        alarm_i <= 16'h0100;
        repeat (4) @(posedge clk_i);
        check(remote_src_o, 1'b1);
        din_sel_en_i <= 1'b0;
        alarm_i <= 16'h0000;
        // silent host, modbus off
        modbus_rtu_i <= 1'b0;
        for (n = 0; n < 80 && comm_timeout_alarm_o !== 1'b1; n++) @(posedge clk_i);
        check({comm_timeout_alarm_o, output_en_o}, 2'b10);
        pcps_host_i.rd(5'h0E, ans);
        check(ans, {1'b1, 16'h8040});
        pcps_host_i.wr(5'h02, 16'h0055, rf);
        check({comm_timeout_alarm_o, output_en_o}, 2'b01);
        // read only: writes refused, watchdog stopped
        pcps_host_i.wr(5'h01, 16'h0001, rf);
        pcps_host_i.wr(5'h02, 16'h00AA, rf);
        check({rf, port_addr_o}, {1'b1, 8'h55});
        repeat (80) @(posedge clk_i);
        check(comm_timeout_alarm_o, 1'b0);
        modbus_rtu_i <= 1'b1;
        do_reset();
        pcps_host_i.rd(5'h0E, ans);
        check(ans, {1'b1, 16'h0004});
        // ramp arms after two off ticks
        pcps_host_i.wr(5'h0B, 16'h0002, rf);
        load_on_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        load_on_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        check(safe_ramp_arm_o, 1'b0);
        for (n = 0; n < 40 && safe_ramp_arm_o !== 1'b1; n++) @(posedge clk_i);
        check(safe_ramp_arm_o, 1'b1);
        pcps_host_i.wr(5'h0A, 16'h0000, rf);
        check({safe_ramp_en_o, safe_ramp_arm_o}, 2'b00);
        complete_run();
    end
endmodule
